// ==== hw/boundary_scan_tap.sv ====
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Every test input, mode select and data in, is sampled on rising test clock.
// - Serial test data output changes only on the falling test clock edge.
// - Controller state machine steps by mode select level at each rising edge.
// - Data in enters the selected register MSB; data out leaves its LSB.
// - The held instruction chooses which register sits between data in and out.
// - Output driver enabled only in Shift-IR and Shift-DR; otherwise high impedance.
// - Five consecutive high mode select edges reach Test-Logic-Reset from any state.
// - Mode select held high keeps Test-Logic-Reset; test logic leaves normal operation alone.
// - Run-Test/Idle holds while mode select low; scans branch from there.
// - In Select-DR-Scan all test data registers keep their contents.
// - Capture-DR parallel-loads selected register; boundary register latches ball levels.
// - Shift-DR shifts selected register one place per clock, in and out.
// - Exit1 leads to Update, Pause suspends shifting, Exit2 may resume shifting.
// - Under external test, boundary parallel outputs update only in Update-DR.
// - Data in and mode select have pull-ups, so may be left open.
// - At power-up the port starts in reset without disturbing the memory.
// - Eight-bit instruction register takes the identity instruction at power-up and reset.
// - Capture-IR loads binary 01 into the two instruction LSBs.
// - Bypass is a one-bit register between data in and out.
// - Identity register captures a hardwired 32-bit code under the identity instruction.
module boundary_scan_tap (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  input wire logic [scan_port_pkg::BSR_WIDTH-1:0] ball_level_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  output logic test_drive_out,
  output logic test_highz_out,
  output logic [scan_port_pkg::BSR_WIDTH-1:0] ball_drive_out
);
  import scan_port_pkg::*;

  // Next controller state for one rising test clock. Five highs on mode select
  // reach Test-Logic-Reset from any state, so a host that lost its place can
  // always find the port again without a reset pin.
  function automatic tap_state_t step(input tap_state_t cur, input logic tms);
    tap_state_t nx;
    nx = tlr_s;
    case (cur)
      // An open mode select reads high through its pad pull-up, so an
      // unconnected port parks here
      tlr_s: nx = tms ? tlr_s : idle_s;
      idle_s: nx = tms ? sel_dr_s : idle_s;
      sel_dr_s: nx = tms ? sel_ir_s : cap_dr_s;
      cap_dr_s: nx = tms ? ex1_dr_s : shf_dr_s;
      shf_dr_s: nx = tms ? ex1_dr_s : shf_dr_s;
      ex1_dr_s: nx = tms ? upd_dr_s : pau_dr_s;
      pau_dr_s: nx = tms ? ex2_dr_s : pau_dr_s;
      ex2_dr_s: nx = tms ? upd_dr_s : shf_dr_s;
      upd_dr_s: nx = tms ? sel_dr_s : idle_s;
      // Instruction branch mirrors the data branch
      sel_ir_s: nx = tms ? tlr_s : cap_ir_s;
      cap_ir_s: nx = tms ? ex1_ir_s : shf_ir_s;
      shf_ir_s: nx = tms ? ex1_ir_s : shf_ir_s;
      ex1_ir_s: nx = tms ? upd_ir_s : pau_ir_s;
      pau_ir_s: nx = tms ? ex2_ir_s : pau_ir_s;
      ex2_ir_s: nx = tms ? upd_ir_s : shf_ir_s;
      upd_ir_s: nx = tms ? sel_dr_s : idle_s;
      default: nx = tlr_s;
    endcase
    return nx;
  endfunction

  // Instructions that place the boundary register between data in and data out
  function automatic logic uses_bsr(input logic [IR_WIDTH-1:0] insn);
    return (insn == INSN_EXTEST) || (insn == INSN_SAMPLE) || (insn == INSN_CLAMP);
  endfunction

  // Instructions under which the update word takes the balls from the memory
  function automatic logic drives_balls(input logic [IR_WIDTH-1:0] insn);
    return (insn == INSN_EXTEST) || (insn == INSN_CLAMP);
  endfunction

  // Identity instruction, decoded at capture, at shift and on the output path
  function automatic logic uses_ident(input logic [IR_WIDTH-1:0] insn);
    return insn == INSN_IDENT;
  endfunction

  // ---------------- Test clock domain ----------------
  // Everything here runs on the test clock only. With that clock held low the
  // whole port is frozen, which is how a board disables it.
  tap_state_t state_ff, nxt_state;
  logic [IR_WIDTH-1:0] ir_shift_ff, nxt_ir_shift;
  // Instruction in force; the shifter beside it may hold a half-loaded one
  logic [IR_WIDTH-1:0] ir_active_ff, nxt_ir_active;
  logic [BSR_WIDTH-1:0] bsr_ff, nxt_bsr;
  // Update word, the value the balls take under external test or clamp
  logic [BSR_WIDTH-1:0] upd_ff, nxt_upd;
  // Identity register reloads its fixed code on each Capture-DR under the identity instruction
  logic [ID_WIDTH-1:0] id_ff, nxt_id;
  logic byp_ff, nxt_byp;
  // Flips once per new instruction or update word bound for the memory side
  logic xfer_tgl_ff, nxt_xfer_tgl;
  logic [BSR_WIDTH-1:0] ball_sync;
  logic serial_bit;

  // Ball levels are asynchronous to the test clock. Capture sees them two test
  // clocks late, so a sample of balls that move in that window may be either
  // value; the trade keeps the capture register free of metastable bits.
  level_sync #(
    .WIDTH(BSR_WIDTH),
    .RESET_VAL(BSR_RESET_VAL)
  ) u_ball_sync (
    .clk_in(tck_in),
    .reset_n_in(reset_n_in),
    .d_in(ball_level_in),
    .q_out(ball_sync)
  );

  always_comb begin
    nxt_state = step(state_ff, tms_in);
    nxt_ir_shift = ir_shift_ff;
    nxt_ir_active = ir_active_ff;
    nxt_bsr = bsr_ff;
    nxt_upd = upd_ff;
    nxt_id = id_ff;
    nxt_byp = byp_ff;
    nxt_xfer_tgl = xfer_tgl_ff;
    case (state_ff)
      tlr_s: begin
        // Mode select held high keeps the port here on every clock. The toggle
        // flips only when the instruction really changes, so the reference side
        // does not re-latch the balls over and over
        nxt_ir_active = IR_RESET_VAL;
        if (ir_active_ff != IR_RESET_VAL) begin
          nxt_xfer_tgl = !xfer_tgl_ff;
        end
      end
      sel_dr_s: begin
        // Data registers hold here
        nxt_bsr = bsr_ff;
      end
      cap_dr_s: begin
        if (uses_bsr(ir_active_ff)) begin
          nxt_bsr = ball_sync;
        end else if (uses_ident(ir_active_ff)) begin
          nxt_id = IDENT_CODE;
        end else begin
          nxt_byp = BYPASS_CAPTURE_VAL;
        end
      end
      shf_dr_s: begin
        if (uses_bsr(ir_active_ff)) begin
          nxt_bsr = {tdi_in, bsr_ff[BSR_WIDTH-1:1]};
        end else if (uses_ident(ir_active_ff)) begin
          nxt_id = {tdi_in, id_ff[ID_WIDTH-1:1]};
        end else begin
          nxt_byp = tdi_in;
        end
      end
      upd_dr_s: begin
        // Sample and clamp load the word too, so a later external test drives
        // preloaded values from its first clock instead of stale ones
        if (uses_bsr(ir_active_ff)) begin
          nxt_upd = bsr_ff;
          nxt_xfer_tgl = !xfer_tgl_ff;
        end
      end
      cap_ir_s: begin
        // Upper bits capture zero; the low 01 lets a board test find a broken chain
        nxt_ir_shift = IR_CAPTURE_VAL;
      end
      shf_ir_s: begin
        nxt_ir_shift = {tdi_in, ir_shift_ff[IR_WIDTH-1:1]};
      end
      upd_ir_s: begin
        // New instruction takes effect here and never while shifting
        nxt_ir_active = ir_shift_ff;
        nxt_xfer_tgl = !xfer_tgl_ff;
      end
      default: begin
        // Idle, pause and exit states hold every register
        nxt_ir_shift = ir_shift_ff;
      end
    endcase
  end

  // Power-up reset puts the port in Test-Logic-Reset
  // with the identity instruction in force
  always_ff @(posedge tck_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff <= tlr_s;
      ir_shift_ff <= IR_RESET_VAL;
      ir_active_ff <= IR_RESET_VAL;
      bsr_ff <= BSR_RESET_VAL;
      upd_ff <= BSR_RESET_VAL;
      id_ff <= IDENT_CODE;
      byp_ff <= BYPASS_CAPTURE_VAL;
      xfer_tgl_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ir_shift_ff <= nxt_ir_shift;
      ir_active_ff <= nxt_ir_active;
      bsr_ff <= nxt_bsr;
      upd_ff <= nxt_upd;
      id_ff <= nxt_id;
      byp_ff <= nxt_byp;
      xfer_tgl_ff <= nxt_xfer_tgl;
    end
  end

  // Serial output path, launched on the falling edge. The far side samples on
  // the rising edge, so it gets half a test clock of settling. Data out keeps
  // its last bit when the driver turns off, so the pad sees no extra edge as
  // the enable drops.
  logic tdo_ff, nxt_tdo;
  logic tdo_oe_ff, nxt_tdo_oe;

  always_comb begin
    // Outside the shift states the choice is a don't-care; the enable masks it
    if (state_ff == shf_ir_s) begin
      serial_bit = ir_shift_ff[0];
    end else if (uses_bsr(ir_active_ff)) begin
      serial_bit = bsr_ff[0];
    end else if (uses_ident(ir_active_ff)) begin
      serial_bit = id_ff[0];
    end else begin
      serial_bit = byp_ff;
    end
    nxt_tdo_oe = (state_ff == shf_ir_s) || (state_ff == shf_dr_s);
    nxt_tdo = nxt_tdo_oe ? serial_bit : tdo_ff;
  end

  // Own reset keeps the pad released from power-up until the first shift
  always_ff @(negedge tck_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tdo_ff <= TDO_RESET_VAL;
      tdo_oe_ff <= 1'b0;
    end else begin
      tdo_ff <= nxt_tdo;
      tdo_oe_ff <= nxt_tdo_oe;
    end
  end

  // Enable and data leave the same clock edge, so the pad never drives a stale bit
  assign tdo_out = tdo_ff;
  assign tdo_oe_out = tdo_oe_ff;

  // ---------------- Memory clock domain ----------------
  // The toggle announces a new instruction or update word. The words it
  // qualifies change again only at the next update, several test clocks
  // later, so they are stable when the reference side copies them.
  // Of the toggle only the synchronised copy is read here; the first stage sits in the helper
  logic tgl_sync;
  logic tgl_seen_ff, nxt_tgl_seen;
  logic drive_ff, nxt_drive;
  logic highz_ff, nxt_highz;
  logic [BSR_WIDTH-1:0] ball_out_ff, nxt_ball_out;

  level_sync #(
    .WIDTH(1),
    .RESET_VAL(1'b0)
  ) u_tgl_sync (
    .clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .d_in(xfer_tgl_ff),
    .q_out(tgl_sync)
  );

  // One event per toggle edge: the balls change once per update, a few
  // reference clocks after the test clock edge that caused it. Reading the
  // words only here keeps the decode off the crossing until it has settled.
  always_comb begin
    nxt_tgl_seen = tgl_sync;
    nxt_drive = drive_ff;
    nxt_highz = highz_ff;
    nxt_ball_out = ball_out_ff;
    if (tgl_sync != tgl_seen_ff) begin
      // Idle instructions leave the balls to normal operation
      nxt_drive = drives_balls(ir_active_ff);
      nxt_highz = (ir_active_ff == INSN_HIGHZ);
      nxt_ball_out = upd_ff;
    end
  end

  // Outputs leave reset in normal operation: no drive and no float
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tgl_seen_ff <= 1'b0;
      drive_ff <= 1'b0;
      highz_ff <= 1'b0;
      ball_out_ff <= BSR_RESET_VAL;
    end else begin
      tgl_seen_ff <= nxt_tgl_seen;
      drive_ff <= nxt_drive;
      highz_ff <= nxt_highz;
      ball_out_ff <= nxt_ball_out;
    end
  end

  assign test_drive_out = drive_ff;
  assign test_highz_out = highz_ff;
  assign ball_drive_out = ball_out_ff;

endmodule

`default_nettype wire

// ==== shared/scan_port_pkg.sv ====
package scan_port_pkg;

  localparam int IR_WIDTH = 8;
  localparam int BSR_WIDTH = 135;
  localparam int ID_WIDTH = 32;

  // Instruction codes; any code not listed behaves as the one-bit bypass path
  localparam logic [IR_WIDTH-1:0] INSN_EXTEST = 8'h00;
  localparam logic [IR_WIDTH-1:0] INSN_IDENT = 8'h01;
  localparam logic [IR_WIDTH-1:0] INSN_SAMPLE = 8'h02;
  localparam logic [IR_WIDTH-1:0] INSN_CLAMP = 8'h03;
  localparam logic [IR_WIDTH-1:0] INSN_HIGHZ = 8'h04;
  localparam logic [IR_WIDTH-1:0] INSN_BYPASS = 8'hFF;

  // Pattern loaded into the instruction shifter on capture
  localparam logic [IR_WIDTH-1:0] IR_CAPTURE_VAL = 8'h01;

  // Arbitrary neutral identity value; bit 0 is set as a scan identity marker
  localparam logic [ID_WIDTH-1:0] IDENT_CODE = 32'h0000_0001;

  // Reset values
  localparam logic [IR_WIDTH-1:0] IR_RESET_VAL = INSN_IDENT;
  localparam logic [BSR_WIDTH-1:0] BSR_RESET_VAL = {BSR_WIDTH{1'b0}};
  localparam logic BYPASS_CAPTURE_VAL = 1'b0;
  localparam logic TDO_RESET_VAL = 1'b0;

  // Synchroniser depth for every crossing
  localparam int SYNC_STAGES = 2;

  typedef enum logic [3:0] {
    tlr_s,
    idle_s,
    sel_dr_s,
    cap_dr_s,
    shf_dr_s,
    ex1_dr_s,
    pau_dr_s,
    ex2_dr_s,
    upd_dr_s,
    sel_ir_s,
    cap_ir_s,
    shf_ir_s,
    ex1_ir_s,
    pau_ir_s,
    ex2_ir_s,
    upd_ir_s
  } tap_state_t;

endpackage

// ==== hw/level_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  import scan_port_pkg::*;

  // First stage is read only by the second stage
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] hold_ff;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_ff <= RESET_VAL;
      hold_ff <= RESET_VAL;
    end else begin
      meta_ff <= d_in;
      hold_ff <= meta_ff;
    end
  end

  assign q_out = hold_ff;

endmodule

`default_nettype wire

// ==== sim/jtag_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module jtag_host_model (
  output var logic tck_out,
  output var logic tms_out,
  output var logic tdi_out,
  input wire logic tdo_in,
  input wire logic tdo_oe_in
);
  // No pull on the data out net: a released pin shows the inverse of the last
  // bit, so a sample taken outside the driven window reads wrong
  wire tdo_pin = tdo_oe_in ? tdo_in : !tdo_in;
  // The memory side is not modelled here; a real controller also keeps
  // mode_reg_one_bit_seven at zero until the calibration pin scan ends
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end
  // Pins move only while the clock is low; it stands still between frames
  task automatic step(input logic mode, input logic data, output logic seen);
    tms_out = mode;
    tdi_out = data;
    #60;
    seen = tdo_pin;
    tck_out = 1'b1;
    #62.5;
    tck_out = 1'b0;
    tdi_out = 1'b1;
    #2.5;
  endtask
  task automatic go_reset;
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
  endtask
  // From idle: scan n bits LSB first; brk is the bit after which it parks in pause
  task automatic scan(input logic ir, input logic [159:0] din, input int n, input int brk,
                      output logic [159:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, q);
    if (ir) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || i == brk, din[i], q);
      dout[i] = q;
      if (i == brk) begin
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
      end
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
endmodule
`default_nettype wire

// ==== sim/boundary_scan_tap_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module scan_tap_sva (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdo_out,
  input wire logic tdo_oe_out,
  input wire logic test_drive_out,
  input wire logic test_highz_out,
  input wire logic [scan_port_pkg::BSR_WIDTH-1:0] ball_drive_out
);
  import scan_port_pkg::*;
  logic tck_seen_ff;
  logic [3:0] quiet_cnt_ff;
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tck_seen_ff <= 1'b0;
      quiet_cnt_ff <= 4'h0;
    end else begin
      tck_seen_ff <= tck_in;
      quiet_cnt_ff <= (tck_in != tck_seen_ff) ? 4'h0
        : quiet_cnt_ff + {3'h0, quiet_cnt_ff != 4'hF};
    end
  end
  sequence tlr_reached;
    tms_in [*5];
  endsequence
  sequence ir_entry;
    tlr_reached ##1 !tms_in ##1 tms_in [*2] ##1 !tms_in [*2];
  endsequence
  sequence dr_entry;
    tlr_reached ##1 !tms_in ##1 tms_in ##1 !tms_in [*2];
  endsequence
  a_tdo_fall_only: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    tck_in && $past(tck_in) |-> $stable(tdo_out)) else $error("data out moved, clock high");
  a_oe_fall_only: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    tck_in && $past(tck_in) |-> $stable(tdo_oe_out)) else $error("enable moved, clock high");
  a_five_ones_reset: assert property (@(posedge tck_in) disable iff (!reset_n_in)
    tlr_reached |=> !tdo_oe_out) else $error("driver on after five ones");
  a_idle_holds: assert property (@(posedge tck_in) disable iff (!reset_n_in)
    tlr_reached ##1 !tms_in [*3] |=> !tdo_oe_out) else $error("driver on in idle");
  a_ir_capture_bit: assert property (@(posedge tck_in) disable iff (!reset_n_in)
    ir_entry |=> tdo_oe_out && tdo_out) else $error("instruction capture bit wrong");
  a_id_first_bit: assert property (@(posedge tck_in) disable iff (!reset_n_in)
    dr_entry |=> tdo_oe_out && tdo_out == IDENT_CODE[0]) else $error("identity bit wrong");
  a_exit_quiet: assert property (@(posedge tck_in) disable iff (!reset_n_in)
    tdo_oe_out && tms_in |=> !tdo_oe_out) else $error("driver on after shift exit");
  a_ref_quiet: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    quiet_cnt_ff > 4'h6 |-> $stable(ball_drive_out) && $stable(test_drive_out)
      && $stable(test_highz_out)) else $error("ball outputs moved without test clock");
endmodule
bind boundary_scan_tap scan_tap_sva scan_tap_sva_inst (.ref_clk_in(ref_clk_in),
  .reset_n_in(reset_n_in), .tck_in(tck_in), .tms_in(tms_in), .tdo_out(tdo_out),
  .tdo_oe_out(tdo_oe_out), .test_drive_out(test_drive_out),
  .test_highz_out(test_highz_out), .ball_drive_out(ball_drive_out));
`default_nettype wire

// ==== sim/boundary_scan_tap_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_tap_bench;
  import scan_port_pkg::*;
  localparam logic [BSR_WIDTH-1:0] PAT = {7'h55, {4{32'hA5C3_0F96}}};
  localparam logic [BSR_WIDTH-1:0] NPAT = ~PAT;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic tck_in, tms_in, tdi_in, tdo_out, tdo_oe_out, test_drive_out, test_highz_out, q;
  logic [BSR_WIDTH-1:0] ball_level_in = PAT;
  logic [BSR_WIDTH-1:0] ball_drive_out;
  logic [159:0] d;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  always #10 ref_clk_in = ~ref_clk_in;
  boundary_scan_tap boundary_scan_tap_inst (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .tck_in(tck_in), .tms_in(tms_in), .tdi_in(tdi_in), .ball_level_in(ball_level_in),
    .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out), .test_drive_out(test_drive_out),
    .test_highz_out(test_highz_out), .ball_drive_out(ball_drive_out));
  jtag_host_model host (.tck_out(tck_in), .tms_out(tms_in), .tdi_out(tdi_in),
    .tdo_in(tdo_out), .tdo_oe_in(tdo_oe_out));
  task automatic check(input logic [159:0] seen, input logic [159:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Ball outputs follow a tck event by a few reference cycles
  task automatic settle;
    repeat (6) @(posedge ref_clk_in);
    #2;
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic t_reset_id;
    host.go_reset();
    host.step(1'b0, 1'b1, q);
    check(tdo_oe_out, 1'b0);
    host.scan(1'b0, '0, 32, -1, d);
    check(d[31:0], IDENT_CODE);
    check(test_drive_out, 1'b0);
    $display("t_reset_id done");
  endtask
  task automatic t_bypass;
    logic [7:0] codes [3] = '{INSN_BYPASS, 8'h5A, INSN_HIGHZ};
    host.go_reset();
    repeat (3) host.step(1'b0, 1'b1, q);
    check(tdo_oe_out, 1'b0);
    foreach (codes[k]) begin
      host.scan(1'b1, codes[k], 8, -1, d);
      check(d[7:0], IR_CAPTURE_VAL);
      host.scan(1'b0, 8'hB4, 8, -1, d);
      check(d[7:0], 8'h68);
      settle();
      check(test_highz_out, codes[k] == INSN_HIGHZ);
    end
    $display("t_bypass done");
  endtask
  task automatic t_boundary;
    host.scan(1'b1, INSN_SAMPLE, 8, -1, d);
    host.scan(1'b0, NPAT, BSR_WIDTH, -1, d);
    check(d[BSR_WIDTH-1:0], PAT);
    settle();
    check({test_drive_out, ball_drive_out}, {1'b0, NPAT});
    ball_level_in = NPAT;
    host.scan(1'b1, INSN_EXTEST, 8, -1, d);
    settle();
    check({test_drive_out, ball_drive_out}, {1'b1, NPAT});
    host.scan(1'b0, PAT, BSR_WIDTH, 60, d);
    check(d[BSR_WIDTH-1:0], NPAT);
    settle();
    check(ball_drive_out, PAT);
    $display("t_boundary done");
  endtask
  task automatic t_clamp;
    host.scan(1'b1, INSN_CLAMP, 8, -1, d);
    settle();
    check({test_drive_out, test_highz_out}, 2'h2);
    host.go_reset();
    settle();
    check(test_drive_out, 1'b0);
    host.step(1'b0, 1'b1, q);
    host.scan(1'b1, INSN_IDENT, 8, -1, d);
    check(d[7:0], IR_CAPTURE_VAL);
    host.scan(1'b0, '0, 32, -1, d);
    check(d[31:0], IDENT_CODE);
    $display("t_clamp done");
  endtask
  initial begin
    repeat (5) @(posedge ref_clk_in);
    #2;
    reset_n_in = 1'b1;
    t_reset_id();
    t_bypass();
    t_boundary();
    t_clamp();
    wrap_up();
  end
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
endmodule
`default_nettype wire
